// ### common/qhbp_pkg.sv
// package for the quad uart host bus port controller
// assumes a single 125 mhz clock domain and an external quad uart on the pins
package qhbp_pkg;
  // ==========================================
  // widths and timing
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int CHAN_W = 2;
  localparam int CLK_PERIOD_NS = 8;
  // strobe low time and setup/hold time, in ns, as plain defaults
  localparam int STROBE_NS = 40;
  localparam int SETUP_NS = 16;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // ==========================================
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_SELS = 4'hf;

  typedef enum logic [1:0] {
    QHBP_IDLE = 2'b00,
    QHBP_SETUP = 2'b01,
    QHBP_STROBE = 2'b11,
    QHBP_HOLD = 2'b10
  } qhbp_state_t;

  // command from user logic
  typedef struct packed {
    logic valid;
    logic read;
    logic [1:0] chan;
    logic [2:0] addr;
    logic [7:0] wdata;
  } qhbp_req_t;

  // pins toward the device
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data_out;
    logic data_oe;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [3:0] chan_select_n;
  } qhbp_pins_t;

  typedef struct packed {
    qhbp_state_t state;
    logic [7:0] cnt;
    logic read;
    logic busy;
    logic done;
    logic [7:0] rdata;
    qhbp_pins_t pins;
  } qhbp_regs_t;
endpackage

// ### hw/qhbp_host.sv
// host controller driving a quad uart parallel register port
// assumes the device pins are asynchronous; read data is double-synchronised
`timescale 1ns/100ps
module qhbp_host (
  input wire logic i_clock, // 125 mhz clock
  input wire logic i_rst_n, // async reset, active low
  input wire logic i_dual_strobe, // bus mode: 1 dual strobe, 0 single select
  input wire qhbp_pkg::qhbp_req_t i_req, // access request, taken when idle
  input wire logic [7:0] i_data_in, // data bus pin level
  output logic o_busy, // access in progress
  output logic o_done, // one-cycle pulse at end of access
  output logic [7:0] o_rdata, // byte read by last read
  output logic [2:0] o_addr, // register address pins
  output logic [7:0] o_data_out, // data bus drive value
  output logic o_data_oe, // data bus output enable
  output logic o_read_strobe_n, // read strobe pin
  output logic o_write_strobe_n, // write strobe or direction pin
  output logic [3:0] o_chan_select_n // chan0..3 selects; 1,2 carry channel bits
);
  // ==========================================
  // reset release and input synchronisers
  logic [1:0] rst_sync;
  logic rst_n;
  logic [7:0] din_meta;
  logic [7:0] din_sync;
  logic mode_meta;
  logic mode_sync;
  qhbp_pkg::qhbp_regs_t r;
  qhbp_pkg::qhbp_regs_t next_r;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      din_meta <= 8'h00;
      din_sync <= 8'h00;
      mode_meta <= 1'b1;
      mode_sync <= 1'b1;
    end else begin
      din_meta <= i_data_in;
      din_sync <= din_meta;
      mode_meta <= i_dual_strobe;
      mode_sync <= mode_meta;
    end
  end

  // ==========================================
  // access sequencer
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    case (r.state)
      qhbp_pkg::QHBP_IDLE: begin
        next_r.busy = 1'b0;
        if (i_req.valid) begin
          next_r.busy = 1'b1;
          next_r.read = i_req.read;
          next_r.cnt = 8'(qhbp_pkg::SETUP_CYC);
          next_r.pins.addr = i_req.addr;
          next_r.pins.data_out = i_req.wdata;
          next_r.pins.data_oe = ~i_req.read;
          next_r.pins.read_strobe_n = 1'b1;
          next_r.pins.write_strobe_n = 1'b1;
          next_r.state = qhbp_pkg::QHBP_SETUP;
          if (mode_sync) begin
            // one low select per channel
            next_r.pins.chan_select_n = ~(4'h1 << i_req.chan);
          end else begin
            next_r.pins.chan_select_n[0] = 1'b1;
            next_r.pins.chan_select_n[1] = i_req.chan[0];
            next_r.pins.chan_select_n[2] = i_req.chan[1];
            next_r.pins.chan_select_n[3] = 1'b1;
            next_r.pins.write_strobe_n = i_req.read;
          end
        end
      end
      qhbp_pkg::QHBP_SETUP: begin
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          next_r.cnt = 8'(qhbp_pkg::STROBE_CYC);
          next_r.state = qhbp_pkg::QHBP_STROBE;
          if (mode_sync) begin
            next_r.pins.read_strobe_n = ~r.read;
            next_r.pins.write_strobe_n = r.read;
          end else begin
            next_r.pins.chan_select_n[0] = 1'b0;
          end
        end
      end
      qhbp_pkg::QHBP_STROBE: begin
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          // sample before the strobe rises; synchroniser adds two cycles,
          // so strobe time must exceed bus access plus that latency
          if (r.read) begin
            next_r.rdata = din_sync;
          end
          next_r.pins.read_strobe_n = 1'b1;
          if (mode_sync) begin
            next_r.pins.write_strobe_n = 1'b1;
          end
          next_r.pins.chan_select_n[0] = mode_sync ? r.pins.chan_select_n[0] : 1'b1;
          next_r.cnt = 8'(qhbp_pkg::SETUP_CYC);
          next_r.state = qhbp_pkg::QHBP_HOLD;
        end
      end
      qhbp_pkg::QHBP_HOLD: begin
        // data and address held past strobe rise
        next_r.cnt = r.cnt - 8'h01;
        if (r.cnt == 8'h01) begin
          next_r.pins.chan_select_n = qhbp_pkg::RST_SELS;
          next_r.pins.write_strobe_n = 1'b1;
          next_r.pins.data_oe = 1'b0;
          next_r.done = 1'b1;
          next_r.busy = 1'b0;
          next_r.state = qhbp_pkg::QHBP_IDLE;
        end
      end
      default: begin
        next_r.state = qhbp_pkg::QHBP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      r.state <= qhbp_pkg::QHBP_IDLE;
      r.cnt <= 8'h00;
      r.read <= 1'b0;
      r.busy <= 1'b0;
      r.done <= 1'b0;
      r.rdata <= qhbp_pkg::RST_BYTE;
      r.pins.addr <= 3'h0;
      r.pins.data_out <= qhbp_pkg::RST_BYTE;
      r.pins.data_oe <= 1'b0;
      r.pins.read_strobe_n <= 1'b1;
      r.pins.write_strobe_n <= 1'b1;
      r.pins.chan_select_n <= qhbp_pkg::RST_SELS;
    end else begin
      r <= next_r;
    end
  end

  assign o_busy = r.busy;
  assign o_done = r.done;
  assign o_rdata = r.rdata;
  assign o_addr = r.pins.addr;
  assign o_data_out = r.pins.data_out;
  assign o_data_oe = r.pins.data_oe;
  assign o_read_strobe_n = r.pins.read_strobe_n;
  assign o_write_strobe_n = r.pins.write_strobe_n;
  assign o_chan_select_n = r.pins.chan_select_n;
endmodule

// ### dv/qhbp_dev.sv
// quad uart register port model, 4 channels of 8 bytes
// assumes the bench resolves the data bus from o_drive
`timescale 1ns/100ps
module qhbp_dev (
  input wire logic i_mode, // bus mode
  input wire logic [2:0] i_addr, // address
  input wire logic [7:0] i_bus, // bus level
  input wire logic i_rd_n, // read strobe
  input wire logic i_wr_n, // write strobe or direction
  input wire logic [3:0] i_sel_n, // selects
  output logic o_drive, // model drives bus
  output logic [7:0] o_q // read byte
);
  logic [7:0] mem [32];
  logic [1:0] ch;
  assign ch = !i_mode ? {i_sel_n[2], i_sel_n[1]} :
    !i_sel_n[1] ? 2'h1 : !i_sel_n[2] ? 2'h2 : !i_sel_n[3] ? 2'h3 : 2'h0;
  assign o_drive = i_mode ? !i_rd_n && i_sel_n != 4'hf : !i_sel_n[0] && i_wr_n;
  assign o_q = mem[{ch, i_addr}];
  always @(posedge i_wr_n) if (i_mode && i_sel_n != 4'hf) mem[{ch, i_addr}] <= i_bus;
  always @(posedge i_sel_n[0]) if (!i_mode && !i_wr_n) mem[{ch, i_addr}] <= i_bus;
  initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 7);
endmodule

// ### dv/qhbp_checker.sv
// pin timing checks for the host bus port
// assumes binding into qhbp_host
`timescale 1ns/100ps
module qhbp_checker (
  input wire logic i_clock, // clock
  input wire logic i_rst_n, // reset
  input wire logic i_dual_strobe, // mode
  input wire logic o_done, // done
  input wire logic [2:0] o_addr, // address
  input wire logic [7:0] o_data_out, // drive value
  input wire logic o_data_oe, // enable
  input wire logic o_read_strobe_n, // read strobe
  input wire logic o_write_strobe_n, // write strobe
  input wire logic [3:0] o_chan_select_n // selects
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  AST_RD_OE: assert property (!o_read_strobe_n |-> !o_data_oe) else $error("bus clash");
  AST_RD_LEN: assert property (
    $fell(o_read_strobe_n) |-> !o_read_strobe_n [*5] ##1 o_read_strobe_n) else $error("rd width");
  AST_WR_LEN: assert property (i_dual_strobe && $fell(o_write_strobe_n) |->
    (!o_write_strobe_n && o_data_oe && $stable(o_data_out)) [*5] ##1 o_write_strobe_n)
    else $error("wr width");
  AST_DUAL_SEL: assert property (i_dual_strobe && !(o_read_strobe_n && o_write_strobe_n) |->
    $countones(o_chan_select_n) == 3) else $error("select count");
  AST_SGL_IDLE: assert property (
    !i_dual_strobe |-> o_read_strobe_n && o_chan_select_n[3]) else $error("unused pin");
  AST_SGL_CS: assert property (!i_dual_strobe && $fell(o_chan_select_n[0]) |->
    (o_data_oe != o_write_strobe_n && $stable({o_addr, o_write_strobe_n, o_chan_select_n[2:1]}))
    [*5] ##1 o_chan_select_n[0]) else $error("select cycle");
  AST_END: assert property (i_dual_strobe ? $rose(o_read_strobe_n && o_write_strobe_n) :
    $rose(o_chan_select_n[0]) |-> ##2 o_done ##1 !o_done) else $error("done timing");
  AST_DONE: assert property (
    o_done |-> o_read_strobe_n && o_write_strobe_n) else $error("strobe at done");
endmodule
bind qhbp_host qhbp_checker u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
  .i_dual_strobe(i_dual_strobe), .o_done(o_done), .o_addr(o_addr), .o_data_out(o_data_out),
  .o_data_oe(o_data_oe), .o_read_strobe_n(o_read_strobe_n),
  .o_write_strobe_n(o_write_strobe_n), .o_chan_select_n(o_chan_select_n));

// ### dv/qhbp_host_tb.sv
// random accesses in both bus modes against the register model
// assumes an idle gap around each mode change
`timescale 1ns/100ps
module qhbp_host_tb;
  logic i_clock = 0, i_rst_n = 0, i_dual_strobe = 1, busy, done, oe, rs_n, ws_n, drv;
  qhbp_pkg::qhbp_req_t i_req = '0;
  logic [7:0] rdata, dout, dq, junk = 8'h5a, last = 8'h00, mirror [32], exp_q [$];
  logic [2:0] addr;
  logic [3:0] sel_n;
  int bad_count = 0, samples_checked = 0;
  // released bus toggles so a missed read cannot pass on stale data
  wire logic [7:0] bus = oe ? dout : drv ? dq : junk;
  always #4 i_clock = ~i_clock;
  always @(posedge i_clock) junk <= ~junk;
  qhbp_host uut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_dual_strobe(i_dual_strobe),
    .i_req(i_req), .i_data_in(bus), .o_busy(busy), .o_done(done), .o_rdata(rdata),
    .o_addr(addr), .o_data_out(dout), .o_data_oe(oe), .o_read_strobe_n(rs_n),
    .o_write_strobe_n(ws_n), .o_chan_select_n(sel_n));
  qhbp_dev dev (.i_mode(i_dual_strobe), .i_addr(addr), .i_bus(bus), .i_rd_n(rs_n),
    .i_wr_n(ws_n), .i_sel_n(sel_n), .o_drive(drv), .o_q(dq));
  task automatic check_byte(input string what, input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic test_done;
    $display("checked %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge i_clock) if (done === 1'b1) check_byte("rdata", rdata, exp_q.pop_front());
  task automatic access(input logic rd, input logic [1:0] ch, input logic [2:0] ad);
    if (rd) last = mirror[{ch, ad}];
    else mirror[{ch, ad}] = junk ^ 8'h3c;
    exp_q.push_back(last);
    i_req <= {1'b1, rd, ch, ad, junk ^ 8'h3c};
    @(posedge i_clock);
    i_req.valid <= 1'b0;
    @(posedge i_clock);
    check_byte("busy", {7'h00, busy}, 8'h01);
    repeat (20) if (done !== 1'b1) @(posedge i_clock);
  endtask
  initial begin
    void'($urandom(32'h67fcc4da));
    for (int i = 0; i < 32; i++) mirror[i] = 8'(i * 7);
    repeat (3) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    for (int m = 0; m < 2; m++) begin
      i_dual_strobe <= m == 0;
      repeat (4) @(posedge i_clock);
      for (int i = 0; i < 40; i++) access(1'($urandom), 2'($urandom), 3'($urandom));
    end
    repeat (4) @(posedge i_clock);
    test_done;
  end
  initial begin
    repeat (5000) @(posedge i_clock);
    bad_count++;
    test_done;
  end
endmodule
